// ### core/gri_regs.svh
`ifndef GRI_REGS_SVH
`define GRI_REGS_SVH
// ==========================================
// Link addressing and code reset value
`define GRI_ADDR_BASE 7'h74
`define GRI_PTR_LAST 8'h1E
`define GRI_PTR_IDLE 8'hFF
`define GRI_COMMON_VOLTAGE_OUTPUT_IDX 5'h12
`define GRI_CODE_RST 10'h200
// ==========================================
// Write target field values
`define GRI_WT_MTP 2'h1
`define GRI_WT_DAC 2'h2
// ==========================================
// Timing: system clock and fastest link clock
`define GRI_CLK_NS 10
`define GRI_SCL_NS 2500
`define GRI_QTR ((`GRI_SCL_NS + 4 * `GRI_CLK_NS - 1) / (4 * `GRI_CLK_NS))
// ==========================================
// Controller register offsets and response codes
`define GRI_OFS_CMD 8'h00
`define GRI_OFS_WDATA 8'h04
`define GRI_OFS_STAT 8'h08
`define GRI_OFS_RDATA 8'h0C
`define GRI_RESP_OK 2'h0
`define GRI_RESP_ERR 2'h2
`endif

// ### core/gri_pkg.sv
package gri_pkg;
	// ==========================================
	// Device end
	typedef enum logic [2:0] {D_IDLE, D_RECV, D_RACK, D_SEND, D_SACK} gri_dst_t;
	typedef struct packed {
		logic [2:0] scl_q;
		logic [2:0] sda_q;
		logic [1:0] sel_q;
		logic [1:0] ot_q;
		gri_dst_t st;
		logic [3:0] cnt;
		logic [1:0] idx;
		logic half;
		logic rw;
		logic [7:0] sh;
		logic [7:0] hold;
		logic [7:0] ptr;
		logic [31:0][9:0] bank;
		logic [16:0][9:0] dac;
		logic dac_ld;
		logic oe;
		logic sta_hi;
		logic gen;
		logic nvm;
	} gri_dev_t;
	// ==========================================
	// Controller end
	typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} gri_mst_t;
	typedef struct packed {
		logic [1:0] sda_q;
		logic [6:0] div;
		logic [1:0] ph;
		logic [3:0] bit_n;
		logic [2:0] bi;
		gri_mst_t st;
		logic rw;
		logic sel;
		logic [7:0] ptr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [7:0] sh;
		logic busy;
		logic nack;
		logic done;
		logic scl_oe;
		logic sda_oe;
		logic awready;
		logic wready;
		logic [7:0] awaddr;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rd;
		logic [1:0] rresp;
	} gri_mreg_t;
endpackage : gri_pkg

// ### core/gri_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Two-wire link with pull-ups on both lines
interface gri_link_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;
	// Wired-and of every driver, released lines read high
	assign scl = !(m_scl_oe && !m_scl_o);
	assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));
	modport mst (input scl, sda, output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe);
	modport dev (input scl, sda, output d_sda_o, d_sda_oe);
endinterface : gri_link_if
`default_nettype wire

// ### core/gri_dev.sv
`timescale 1ns/1ns
`default_nettype none
`include "gri_regs.svh"
module gri_dev import gri_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Two-wire link
	gri_link_if.dev link,
	// Strap and temperature flag
	input wire logic address_select_pin,
	input wire logic over_temp,
	// Channel codes and controls
	output logic [15:0][9:0] gamma_reference_outputs,
	output logic [9:0] common_voltage_output,
	output logic gamma_enable,
	output logic nvm_store_req
);

	// ==========================================
	// Helpers
	// Next pointer after a full word; the last location parks idle
	function automatic logic [7:0] ptr_next(input logic [7:0] p);
		if (p == `GRI_PTR_LAST || p == `GRI_PTR_IDLE) begin
			ptr_next = `GRI_PTR_IDLE;
		end else begin
			ptr_next = p + 8'h01;
		end
	endfunction : ptr_next

	// Byte of a word to send; past the map reads all ones
	function automatic logic [7:0] rd_byte(input logic [9:0] w,
		input logic [7:0] p, input logic lo);
		if (p > `GRI_PTR_LAST) begin
			rd_byte = 8'hFF;
		end else if (lo) begin
			rd_byte = w[7:0];
		end else begin
			rd_byte = {6'h00, w[9:8]};
		end
	endfunction : rd_byte

	// ==========================================
	// State
	gri_dev_t s;
	gri_dev_t n;
	logic rise;
	logic fall;
	logic hi;
	logic sta;
	logic sto;
	logic [6:0] my_addr;
	logic [7:0] tx;

	// Edge and condition decode on the synchronised copies only
	assign rise = s.scl_q[1] && !s.scl_q[2];
	assign fall = !s.scl_q[1] && s.scl_q[2];
	assign hi = s.scl_q[1] && s.scl_q[2];
	assign sta = hi && s.sda_q[2] && !s.sda_q[1];
	assign sto = hi && !s.sda_q[2] && s.sda_q[1];
	assign my_addr = `GRI_ADDR_BASE | {6'h00, s.sel_q[1]};
	assign tx = rd_byte(s.bank[s.ptr[4:0]], s.ptr, s.half);

	// ==========================================
	// Next-state logic
	always_comb begin
		n = s;
		n.scl_q = {s.scl_q[1:0], link.scl};
		n.sda_q = {s.sda_q[1:0], link.sda};
		n.sel_q = {s.sel_q[0], address_select_pin};
		n.ot_q = {s.ot_q[0], over_temp};
		n.gen = !s.ot_q[1];
		n.nvm = 1'b0;
		n.dac_ld = 1'b0;
		// Copy bank entries 0 to 15 and the common voltage entry into the channel codes
		if (s.dac_ld) begin
			for (int i = 0; i < 16; i++) begin
				n.dac[i] = s.bank[i];
			end
			n.dac[16] = s.bank[`GRI_COMMON_VOLTAGE_OUTPUT_IDX];
		end
		if (fall) begin
			n.sta_hi = 1'b0;
		end
		if (sta) begin
			// Start or repeated start: new frame, bus stays held
			n.st = D_RECV;
			n.cnt = 4'h0;
			n.idx = 2'h0;
			n.oe = 1'b0;
			n.sta_hi = 1'b1;
		end else if (sto && !s.sta_hi) begin
			n.st = D_IDLE;
			n.oe = 1'b0;
		end else begin
			case (s.st)
				D_RECV: begin
					if (rise) begin
						// Sample at clock high, MSB first
						n.sh = {s.sh[6:0], s.sda_q[1]};
						n.cnt = s.cnt + 4'h1;
					end else if (fall && s.cnt == 4'h8) begin
						n.cnt = 4'h0;
						n.oe = 1'b1;
						n.st = D_RACK;
						case (s.idx)
							2'h0: begin
								if (s.sh[7:1] == my_addr) begin
									n.rw = s.sh[0];
									n.half = 1'b0;
								end else begin
									n.oe = 1'b0;
									n.st = D_IDLE;
								end
							end
							2'h1: begin
								n.ptr = s.sh;
								n.half = 1'b0;
							end
							default: begin
								if (!s.half) begin
									n.hold = s.sh;
									n.half = 1'b1;
								end else begin
									n.half = 1'b0;
									n.ptr = ptr_next(s.ptr);
									if (s.ptr <= `GRI_PTR_LAST) begin
										// Only the low ten bits are kept
										n.bank[s.ptr[4:0]] = {s.hold[1:0], s.sh};
									end
									if (s.hold[7:6] == `GRI_WT_DAC) begin
										n.dac_ld = 1'b1;
									end
									if (s.hold[7:6] == `GRI_WT_MTP) begin
										n.nvm = 1'b1;
									end
								end
							end
						endcase
					end
				end
				D_RACK: begin
					// Release after the whole ninth pulse
					if (fall) begin
						n.oe = 1'b0;
						if (s.idx == 2'h0 && s.rw) begin
							n.st = D_SEND;
							n.sh = tx;
							n.oe = !tx[7];
						end else begin
							n.st = D_RECV;
							n.idx = (s.idx == 2'h0) ? 2'h1 : 2'h2;
						end
					end
				end
				D_SEND: begin
					// Shift out on each falling edge
					if (rise) begin
						n.cnt = s.cnt + 4'h1;
					end else if (fall) begin
						if (s.cnt == 4'h8) begin
							n.cnt = 4'h0;
							n.oe = 1'b0;
							n.st = D_SACK;
						end else begin
							n.sh = {s.sh[6:0], 1'b0};
							n.oe = !s.sh[6];
						end
					end
				end
				D_SACK: begin
					if (rise) begin
						n.half = !s.half;
						if (s.half) begin
							n.ptr = ptr_next(s.ptr);
						end
						if (s.sda_q[1]) begin
							n.st = D_IDLE;
						end
					end else if (fall) begin
						n.st = D_SEND;
						n.sh = tx;
						n.oe = !tx[7];
					end
				end
				default: begin
					n.oe = 1'b0;
				end
			endcase
		end
	end

	// ==========================================
	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.scl_q <= 3'h7;
			s.sda_q <= 3'h7;
			s.st <= D_IDLE;
			s.ptr <= `GRI_PTR_IDLE;
			s.bank <= {32{`GRI_CODE_RST}};
			s.dac <= {17{`GRI_CODE_RST}};
		end else begin
			s <= n;
		end
	end

	// ==========================================
	// Outputs
	assign link.d_sda_o = 1'b0;
	assign link.d_sda_oe = s.oe;
	assign gamma_reference_outputs = s.dac[15:0];
	assign common_voltage_output = s.dac[16];
	assign gamma_enable = s.gen;
	assign nvm_store_req = s.nvm;

endmodule : gri_dev
`default_nettype wire

// ### core/gri_mst.sv
`timescale 1ns/1ns
`default_nettype none
`include "gri_regs.svh"
module gri_mst import gri_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus write
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Register bus read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Two-wire link
	gri_link_if.mst link
);

	// ==========================================
	// Byte to send for each slot of the frame
	function automatic logic [7:0] tx_byte(input logic [2:0] bi,
		input logic rw, input logic [6:0] a, input logic [7:0] p,
		input logic [15:0] d);
		case (bi)
			3'h0: tx_byte = {a, 1'b0};
			3'h1: tx_byte = p;
			3'h2: tx_byte = rw ? {a, 1'b1} : d[15:8];
			3'h3: tx_byte = d[7:0];
			default: tx_byte = 8'hFF;
		endcase
	endfunction : tx_byte

	gri_mreg_t s;
	gri_mreg_t n;
	logic tick;
	logic rx;
	logic [6:0] addr;
	logic [7:0] tb;

	assign tick = (s.div == 7'(`GRI_QTR - 1));
	assign rx = s.rw && s.bi >= 3'h3;
	assign addr = `GRI_ADDR_BASE | {6'h00, s.sel};
	assign tb = tx_byte(s.bi, s.rw, addr, s.ptr, s.wdata);

	// ==========================================
	// Next-state logic
	always_comb begin
		n = s;
		n.sda_q = {s.sda_q[0], link.sda};
		// Register bus write channel
		if (s.bvalid && bready) begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end
		if (awvalid && s.awready) begin
			n.awaddr = awaddr;
			n.awready = 1'b0;
		end
		if (wvalid && s.wready) begin
			n.wd = wdata;
			n.ws = wstrb;
			n.wready = 1'b0;
		end
		if (!s.awready && !s.wready && !s.bvalid) begin
			n.bvalid = 1'b1;
			n.bresp = `GRI_RESP_OK;
			case (s.awaddr)
				`GRI_OFS_CMD: begin
					if (s.ws[0] && s.wd[0] && !s.busy) begin
						n.busy = 1'b1;
						n.done = 1'b0;
						n.nack = 1'b0;
						n.rw = s.wd[1];
						n.sel = s.wd[2];
						if (s.ws[1]) begin
							n.ptr = s.wd[15:8];
						end
						n.st = M_START;
						n.ph = 2'h0;
						n.bi = 3'h0;
						n.div = 7'h00;
					end
				end
				`GRI_OFS_WDATA: begin
					if (s.ws[0]) begin
						n.wdata[7:0] = s.wd[7:0];
					end
					if (s.ws[1]) begin
						n.wdata[15:8] = s.wd[15:8];
					end
				end
				`GRI_OFS_STAT, `GRI_OFS_RDATA: begin
					n.bresp = `GRI_RESP_OK;
				end
				default: begin
					n.bresp = `GRI_RESP_ERR;
				end
			endcase
		end
		// Register bus read channel
		if (s.rvalid && rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end
		if (arvalid && s.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = `GRI_RESP_OK;
			case (araddr)
				`GRI_OFS_CMD: n.rd = {16'h0000, s.ptr, 5'h00, s.sel, s.rw, 1'b0};
				`GRI_OFS_WDATA: n.rd = {16'h0000, s.wdata};
				`GRI_OFS_STAT: n.rd = {29'h0000_0000, s.done, s.nack, s.busy};
				`GRI_OFS_RDATA: n.rd = {16'h0000, s.rdata};
				default: begin
					n.rd = 32'h0000_0000;
					n.rresp = `GRI_RESP_ERR;
				end
			endcase
		end
		// Quarter-period divider for the link clock
		if (s.st != M_IDLE) begin
			n.div = tick ? 7'h00 : s.div + 7'h01;
		end
		if (tick && s.st != M_IDLE) begin
			n.ph = s.ph + 2'h1;
			case (s.st)
				M_START: begin
					// Data released, clock up, data down, clock down
					case (s.ph)
						2'h0: n.sda_oe = 1'b0;
						2'h1: n.scl_oe = 1'b0;
						2'h2: n.sda_oe = 1'b1;
						default: begin
							n.scl_oe = 1'b1;
							n.st = M_BIT;
							n.bit_n = 4'h0;
						end
					endcase
				end
				M_BIT: begin
					case (s.ph)
						2'h0: begin
							// Data changes only while clock low
							if (s.bit_n < 4'h8) begin
								n.sda_oe = !rx && !tb[3'h7 - s.bit_n[2:0]];
							end else begin
								n.sda_oe = rx && s.bi != 3'h4;
							end
						end
						2'h1: n.scl_oe = 1'b0;
						2'h2: begin
							if (s.bit_n < 4'h8) begin
								n.sh = {s.sh[6:0], s.sda_q[1]};
							end else if (!rx && s.sda_q[1]) begin
								n.nack = 1'b1;
							end
						end
						default: begin
							n.scl_oe = 1'b1;
							n.bit_n = s.bit_n + 4'h1;
							if (s.bit_n == 4'h8) begin
								n.bit_n = 4'h0;
								n.bi = s.bi + 3'h1;
								if (s.bi == 3'h3) begin
									n.rdata[15:8] = s.sh;
								end
								if (s.bi == 3'h4) begin
									n.rdata[7:0] = s.sh;
								end
								if (s.nack || (!s.rw && s.bi == 3'h3)) begin
									n.st = M_STOP;
								end else if (s.rw && s.bi == 3'h1) begin
									n.st = M_START;
								end else if (s.rw && s.bi == 3'h4) begin
									n.st = M_STOP;
								end
							end
						end
					endcase
				end
				M_STOP: begin
					// Data low, clock up, then data released
					case (s.ph)
						2'h0: n.sda_oe = 1'b1;
						2'h1: n.scl_oe = 1'b0;
						2'h2: n.sda_oe = 1'b0;
						default: begin
							n.st = M_IDLE;
							n.busy = 1'b0;
							n.done = 1'b1;
						end
					endcase
				end
				default: n.st = M_IDLE;
			endcase
		end
	end

	// ==========================================
	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.sda_q <= 2'h3;
			s.st <= M_IDLE;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ==========================================
	// Outputs
	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rd;
	assign rresp = s.rresp;
	assign link.m_scl_o = 1'b0;
	assign link.m_scl_oe = s.scl_oe;
	assign link.m_sda_o = 1'b0;
	assign link.m_sda_oe = s.sda_oe;

endmodule : gri_mst
`default_nettype wire

// ### verif/gri_link_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Link protocol checker
module gri_link_chk (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link signals
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic d_sda_o,
	input wire logic d_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q;
	logic sda_q;
	logic sta_hi;
	logic [3:0] pcnt;
	logic [9:0] per_cnt;
	logic [9:0] hi_cnt;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Pulse count per byte, start seen in this high pulse, clock timing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sta_hi <= 1'b0;
			pcnt <= 4'h0;
			per_cnt <= 10'h3FF;
			hi_cnt <= 10'h0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			sta_hi <= scl && (sta_hi || (scl_q && sda_q && !sda));
			if (scl && scl_q && sda_q && !sda) begin
				pcnt <= 4'h0;
			end else if (scl && !scl_q) begin
				pcnt <= (pcnt == 4'h9) ? 4'h1 : pcnt + 4'h1;
			end
			per_cnt <= (scl && !scl_q) ? 10'h0 : per_cnt + {9'h0, per_cnt != 10'h3FF};
			hi_cnt <= !scl ? 10'h0 : hi_cnt + {9'h0, hi_cnt != 10'h3FF};
		end
	end
	chk_mst_open_drain: assert property (!m_scl_o && !m_sda_o)
		else $error("controller drives a line high");
	chk_dev_open_drain: assert property (!d_sda_o)
		else $error("device drives data high");
	chk_dev_data_stable: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
		else $error("device data changed while clock high");
	chk_mst_data_stable: assert property (scl && $past(scl) && $changed(m_sda_oe) |-> pcnt <= 4'h1)
		else $error("controller data changed inside a bit");
	chk_no_stop_start: assert property (scl && sta_hi |-> !$rose(sda))
		else $error("stop in the start pulse");
	chk_stop_on_byte: assert property (scl && $rose(sda) |-> pcnt == 4'h1)
		else $error("stop not on a byte boundary");
	chk_clk_period: assert property ($rose(scl) |-> per_cnt >= 10'd249)
		else $error("clock period too short");
	chk_clk_high: assert property ($fell(scl) |-> m_scl_oe && hi_cnt >= 10'd59)
		else $error("clock high pulse too short");
endmodule : gri_link_chk
`default_nettype wire

// ### verif/tb_gamma_reference_i2c_slave.sv
`timescale 1ns/1ns
`default_nettype none
`include "gri_regs.svh"
// ==========================================
// Controller and device joined over the link
module tb_gamma_reference_i2c_slave import gri_pkg::*;;
	typedef struct packed {
		logic pin;
		logic [7:0] ptr;
		logic [15:0] word;
		logic [9:0] code;
		logic nvm;
	} gri_row_t;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, gamma_enable, nvm_store_req;
	logic address_select_pin, over_temp;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, s;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [15:0][9:0] gamma_reference_outputs;
	logic [9:0] common_voltage_output;
	int error_cnt, checks, nvm_cnt, k;
	gri_row_t rows [4];
	gri_link_if link();
	gri_mst i_gri_mst (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata, .rresp, .link(link));
	gri_dev i_gri_dev (.aclk, .aresetn, .link(link), .address_select_pin,
		.over_temp, .gamma_reference_outputs, .common_voltage_output,
		.gamma_enable, .nvm_store_req);
	gri_link_chk i_gri_link_chk (.aclk, .aresetn, .m_scl_o(link.m_scl_o),
		.m_scl_oe(link.m_scl_oe), .m_sda_o(link.m_sda_o),
		.m_sda_oe(link.m_sda_oe), .d_sda_o(link.d_sda_o),
		.d_sda_oe(link.d_sda_oe), .scl(link.scl), .sda(link.sda));
	// Clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Count store pulses
	always @(posedge aclk) begin
		if (nvm_store_req === 1'b1) nvm_cnt <= nvm_cnt + 1;
	end
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic end_sim();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	task automatic give_up();
		error_cnt++;
		$display("MISMATCH wait expected answer seen timeout");
		end_sim();
	endtask : give_up
	// Register bus write, waits for the response
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				break;
			end
		end
		bready <= 1'b0;
		if (n == 64) give_up();
	endtask : axw
	// Register bus read
	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				break;
			end
		end
		rready <= 1'b0;
		if (n == 64) give_up();
	endtask : axr
	// Start a link frame and poll status until the stop has ended
	task automatic frame(input logic [31:0] cmd);
		int n;
		axw(`GRI_OFS_CMD, cmd, r);
		for (n = 0; n < 8000; n++) begin
			axr(`GRI_OFS_STAT, s);
			// Nack shows before the stop; a new go while busy is ignored
			if (s[2] && !s[0]) break;
		end
		if (n == 8000) give_up();
	endtask : frame
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{address_select_pin, over_temp, awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		rows[0] = '{1'b0, 8'h01, 16'h4123, 10'h200, 1'b1};
		rows[1] = '{1'b0, 8'h00, 16'h8155, 10'h155, 1'b0};
		rows[2] = '{1'b1, 8'h12, 16'h8001, 10'h001, 1'b0};
		rows[3] = '{1'b1, 8'h0F, 16'hC3FF, 10'h200, 1'b0};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
		cmp("ch0 reset", 16'h0200, {6'h0, gamma_reference_outputs[0]});
		cmp("common reset", 16'h0200, {6'h0, common_voltage_output});
		cmp("enable", 16'h0001, {15'h0, gamma_enable});
		cmp("idle lines", 16'h0003, {14'h0, link.scl, link.sda});
		axw(8'h10, 32'h0, r);
		cmp("unmapped", 16'h0002, {14'h0, r});
		// One word write per row
		foreach (rows[i]) begin
			k = nvm_cnt;
			address_select_pin <= rows[i].pin;
			axw(`GRI_OFS_WDATA, {16'h0, rows[i].word}, r);
			frame({16'h0, rows[i].ptr, 5'h0, rows[i].pin, 2'b01});
			cmp("status", 16'h0004, s[15:0]);
			cmp("code", {6'h0, rows[i].code}, {6'h0, rows[i].ptr == 8'h12 ?
				common_voltage_output : gamma_reference_outputs[rows[i].ptr[3:0]]});
			cmp("store", {15'h0, rows[i].nvm}, 16'(nvm_cnt - k));
		end
		// Strap mismatch: no acknowledge, nothing changes
		address_select_pin <= 1'b0;
		frame(32'h0000_0005);
		cmp("nack", 16'h0001, {15'h0, s[1]});
		cmp("ch0 kept", 16'h0155, {6'h0, gamma_reference_outputs[0]});
		// Read back with a repeated start
		frame(32'h0000_0003);
		cmp("read status", 16'h0004, s[15:0]);
		axr(`GRI_OFS_RDATA, s);
		cmp("read word", 16'h0155, s[15:0]);
		// Overheat disables and re-enables the gamma outputs
		over_temp <= 1'b1;
		repeat (5) @(posedge aclk);
		cmp("disabled", 16'h0000, {15'h0, gamma_enable});
		over_temp <= 1'b0;
		repeat (5) @(posedge aclk);
		cmp("enabled", 16'h0001, {15'h0, gamma_enable});
		// Second reset in mid-run
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		cmp("ch0 again", 16'h0200, {6'h0, gamma_reference_outputs[0]});
		end_sim();
	end
endmodule : tb_gamma_reference_i2c_slave
`default_nettype wire
